// File: rtl/backlash_sequence_controller.v
`timescale 1ns/1ps
`include "gear_play_map.vh"
module backlash_sequence_controller (
  input wire clock,
  input wire rst_b,
  input wire load_variation,
  input wire run_order,
  input wire halt,
  input wire direction,
  input wire closed_loop,
  input wire master_request,
  input wire link_mode,
  input wire master_role,
  input wire cfg_write,
  input wire [2:0] cfg_reaction,
  input wire [1:0] cfg_gear_play_mode,
  input wire cfg_gear_play_sequencing,
  input wire cfg_slave_done_feedback_use,
  input wire [`SLAVE_TIME_W-1:0] slave_time,
  input wire torque_limit_reached,
  input wire [`NSLAVE-1:0] slave_done,
  output reg [2:0] drive_cmd,
  output reg torque_limit_on,
  output reg sequence_busy,
  output reg [`NSLAVE-1:0] slave_comp,
  output reg load_error_out,
  output reg reaction_active_out,
  output reg [`NSLAVE-1:0] slave_flags_out
);
  localparam S_IDLE = 3'h0;
  localparam S_RUN = 3'h1;
  localparam S_SLAVES = 3'h2;
  localparam S_MASTER = 3'h3;
  localparam S_REV_STOP = 3'h4;
  localparam S_REV_ZERO = 3'h5;

  reg [2:0] reaction;
  reg [1:0] gear_play_mode;
  reg gear_play_sequencing;
  reg slave_done_feedback_use;
  reg [2:0] state;
  reg [2:0] next_state;
  reg run_q;
  reg halt_q;
  reg dir_q;
  reg [`SLAVE_IDX_W-1:0] slave_idx;
  reg [`SLAVE_TIME_W-1:0] slave_cnt;
  reg flag_clear;
  reg [2:0] next_cmd;
  wire [2:0] react_cmd;
  wire react_active;
  wire load_error;
  wire [`NSLAVE-1:0] flags;
  wire all_done;
  wire start_event;
  wire dir_change;
  wire ms_ok;
  wire seq_sim;
  wire slot_end;
  wire [`SLAVE_IDX_W-1:0] next_idx;

  function [`NSLAVE-1:0] onehot;
    input [`SLAVE_IDX_W-1:0] idx;
    begin
      onehot = {{(`NSLAVE-1){1'b0}}, 1'b1} << idx;
    end
  endfunction

  // Configuration: defaults apply after reset
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reaction <= `REACT_RESET;
      gear_play_mode <= `MODE_RESET;
      gear_play_sequencing <= `SEQ_RESET;
      slave_done_feedback_use <= `FDBK_RESET;
    end else if (cfg_write) begin
      reaction <= cfg_reaction;
      gear_play_mode <= cfg_gear_play_mode;
      gear_play_sequencing <= cfg_gear_play_sequencing;
      slave_done_feedback_use <= cfg_slave_done_feedback_use;
    end
  end

  // Start: run order rises, or halt releases while run order stands
  assign start_event = (run_order & ~run_q) |
    (run_order & halt_q & ~halt);
  assign dir_change = run_order & (direction != dir_q);
  // Coordination only with compensation on, link mode and master role
  assign ms_ok = (gear_play_mode != `MODE_OFF) & link_mode &
    master_role;
  assign seq_sim = ms_ok & (gear_play_sequencing == `SEQ_SIMULTANEOUS);
  assign slot_end = slave_done_feedback_use ? 1'b0 :
    (slave_cnt == slave_time);
  assign next_idx = slave_idx + 1'b1;

  load_error_reaction u_react (
    .clock(clock),
    .rst_b(rst_b),
    .load_variation(load_variation),
    .run_order(run_order),
    .reaction(reaction),
    .react_cmd(react_cmd),
    .react_active(react_active),
    .load_error(load_error)
  );

  slave_done_flags u_flags (
    .clock(clock),
    .rst_b(rst_b),
    .clear(flag_clear),
    .done_in(slave_done),
    .flags(flags),
    .all_done(all_done)
  );

  always @* begin
    next_state = state;
    flag_clear = 1'b0;
    case (state)
      S_IDLE: begin
        if (run_order && !halt) begin
          if (gear_play_mode == `MODE_OFF) begin
            next_state = S_RUN;
          end else if (gear_play_mode == `MODE_MASTER) begin
            // Local starts ignored here
            // Slaves go first when coordination is allowed
            if (master_request && ms_ok) begin
              next_state = S_SLAVES;
              flag_clear = 1'b1;
            end else if (master_request) begin
              next_state = S_MASTER;
            end
          end else if (start_event && ms_ok) begin
            next_state = S_SLAVES;
            flag_clear = 1'b1;
          end else if (start_event) begin
            next_state = S_MASTER;
          end
        end
      end
      S_RUN: begin
        if (!run_order || halt) begin
          next_state = S_IDLE;
        end else if (dir_change &&
                     gear_play_mode == `MODE_START_DIR) begin
          // Reverse handling follows the loop type
          next_state = closed_loop ? S_REV_ZERO : S_REV_STOP;
        end
        // Already running: no new sequence
      end
      S_REV_STOP: begin
        if (!run_order) next_state = S_IDLE;
        else next_state = S_MASTER;
      end
      S_REV_ZERO: begin
        next_state = S_MASTER;
      end
      S_SLAVES: begin
        if (!run_order) begin
          next_state = S_IDLE;
        end else if (slave_done_feedback_use) begin
          if (all_done) next_state = S_MASTER;
        end else if (slot_end) begin
          if (seq_sim || slave_idx == `NSLAVE-1)
            next_state = S_MASTER;
        end
      end
      S_MASTER: begin
        if (!run_order) next_state = S_IDLE;
        else if (torque_limit_reached) next_state = S_RUN;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always @* begin
    // Follows the coming state so command and phase outputs line up
    case (next_state)
      S_RUN: next_cmd = `CMD_RUN;
      S_MASTER: next_cmd = `CMD_RUN;
      S_REV_STOP: next_cmd = `CMD_RAMP;
      S_REV_ZERO: next_cmd = `CMD_ZERO;
      // Master parked while slaves work
      S_SLAVES: next_cmd = closed_loop ? `CMD_ZERO : `CMD_RAMP;
      default: next_cmd = `CMD_RAMP;
    endcase
    // Reaction overrides sequencing; ignore leaves it alone
    if (react_active) next_cmd = react_cmd;
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      run_q <= 1'b0;
      halt_q <= 1'b0;
      dir_q <= 1'b0;
      slave_idx <= {`SLAVE_IDX_W{1'b0}};
      slave_cnt <= {`SLAVE_TIME_W{1'b0}};
      drive_cmd <= `CMD_RAMP;
      torque_limit_on <= 1'b0;
      sequence_busy <= 1'b0;
      slave_comp <= {`NSLAVE{1'b0}};
      load_error_out <= 1'b0;
      reaction_active_out <= 1'b0;
      slave_flags_out <= {`NSLAVE{1'b0}};
    end else begin
      state <= next_state;
      run_q <= run_order;
      halt_q <= halt;
      dir_q <= direction;
      if (state != S_SLAVES) begin
        slave_idx <= {`SLAVE_IDX_W{1'b0}};
        slave_cnt <= {`SLAVE_TIME_W{1'b0}};
      end else if (slot_end) begin
        slave_idx <= slave_idx + 1'b1;
        slave_cnt <= {`SLAVE_TIME_W{1'b0}};
      end else begin
        slave_cnt <= slave_cnt + 1'b1;
      end
      drive_cmd <= next_cmd;
      torque_limit_on <= (next_state == S_MASTER);
      sequence_busy <= (next_state == S_SLAVES) ||
        (next_state == S_MASTER);
      if (next_state != S_SLAVES) begin
        slave_comp <= {`NSLAVE{1'b0}};
      end else if (seq_sim) begin
        // All together; in controlled mode each drops on report
        slave_comp <= slave_done_feedback_use ?
          ~flags & ~slave_done : {`NSLAVE{1'b1}};
      end else if (slave_done_feedback_use) begin
        // First slave not yet reported is active
        slave_comp <= (~flags & ~slave_done) &
          ~((~flags & ~slave_done) - 1'b1);
      end else if (state == S_SLAVES && slot_end) begin
        slave_comp <= onehot(next_idx);
      end else begin
        slave_comp <= onehot(slave_idx);
      end
      // Indication for routing to a relay or logic output
      load_error_out <= load_error;
      reaction_active_out <= react_active;
      slave_flags_out <= flags;
    end
  end
endmodule // backlash_sequence_controller

// File: rtl/gear_play_map.vh
// Contract
// - Load error applies selected reaction: ignore, freewheel, stop type, fallback, hold, ramp, fast
// - Fallback reaction holds fallback speed while error and run order persist
// - Hold reaction keeps present speed while error and run order persist
// - Stop-type reaction stops by stop type, no error raised afterwards (load_error is still set here, as for every reaction)
// - Reaction selector resets to freewheel stop
// - Sequence runs speed under torque limit until load stalls, then run resumes
// - Open loop uses stop on reverse; closed loop uses zero speed on reverse
// - Start-only case compensates at start, transparent while running
// - Open loop reverse: stop, then restart with sequence if run order remains
// - Closed loop reverse: hold zero speed, compensate, return to run
// - Start mode compensates on run order rise or halt release; default off
// - Start plus direction mode also compensates on each direction change
// - Master request mode compensates only via master/slave coordination
// - While slaves compensate master stops (open) or holds zero speed (closed)
// - Direct sequential: slaves one at a time within time, then master
// - Direct simultaneous: all slaves together within time, no feedback
// - Controlled sequential: slaves one at a time, each reports, then master
// - Controlled simultaneous: slaves together, each reports, master after last
// - Sequencing type used only when enabled, link mode and master role
// - Sequencing type defaults to sequential
// - Load variation detection raises load error, which selects the reaction
// - Feedback use selects controlled or direct strategy; default uses feedback
`ifndef GEAR_PLAY_MAP_VH
`define GEAR_PLAY_MAP_VH
`define REACT_IGNORE 3'h0
`define REACT_FREEWHEEL 3'h1
`define REACT_STOP_TYPE 3'h2
`define REACT_FALLBACK 3'h3
`define REACT_HOLD 3'h4
`define REACT_RAMP 3'h5
`define REACT_FAST 3'h6
`define REACT_RESET 3'h1
`define MODE_OFF 2'h0
`define MODE_START 2'h1
`define MODE_START_DIR 2'h2
`define MODE_MASTER 2'h3
`define MODE_RESET 2'h0
`define SEQ_SEQUENTIAL 1'b0
`define SEQ_SIMULTANEOUS 1'b1
`define SEQ_RESET 1'b0
`define FDBK_RESET 1'b1
`define NSLAVE 4
`define SLAVE_IDX_W 2
`define SLAVE_TIME_W 16
`define CMD_RUN 3'h0
`define CMD_FREEWHEEL 3'h1
`define CMD_STOP_TYPE 3'h2
`define CMD_FALLBACK 3'h3
`define CMD_HOLD 3'h4
`define CMD_RAMP 3'h5
`define CMD_FAST 3'h6
`define CMD_ZERO 3'h7
`endif

// File: rtl/load_error_reaction.v
`timescale 1ns/1ps
`include "gear_play_map.vh"
module load_error_reaction (
  input wire clock,
  input wire rst_b,
  input wire load_variation,
  input wire run_order,
  input wire [2:0] reaction,
  output reg [2:0] react_cmd,
  output reg react_active,
  output reg load_error
);
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      react_cmd <= `CMD_RUN;
      react_active <= 1'b0;
      load_error <= 1'b0;
    end else begin
      load_error <= load_variation;
      react_active <= 1'b0;
      react_cmd <= `CMD_RUN;
      if (load_variation) begin
        case (reaction)
          `REACT_IGNORE: react_cmd <= `CMD_RUN;
          `REACT_FREEWHEEL: begin
            react_cmd <= `CMD_FREEWHEEL;
            react_active <= 1'b1;
          end
          `REACT_STOP_TYPE: begin
            // Stop by stop type; load_error is still raised, as for every reaction
            react_cmd <= `CMD_STOP_TYPE;
            react_active <= 1'b1;
          end
          `REACT_FALLBACK: begin
            if (run_order) begin
              react_cmd <= `CMD_FALLBACK;
              react_active <= 1'b1;
            end
          end
          `REACT_HOLD: begin
            if (run_order) begin
              react_cmd <= `CMD_HOLD;
              react_active <= 1'b1;
            end
          end
          `REACT_RAMP: begin
            react_cmd <= `CMD_RAMP;
            react_active <= 1'b1;
          end
          `REACT_FAST: begin
            react_cmd <= `CMD_FAST;
            react_active <= 1'b1;
          end
          default: react_cmd <= `CMD_RUN;
        endcase
      end
    end
  end
endmodule // load_error_reaction

// File: rtl/slave_done_flags.v
`timescale 1ns/1ps
`include "gear_play_map.vh"
module slave_done_flags (
  input wire clock,
  input wire rst_b,
  input wire clear,
  input wire [`NSLAVE-1:0] done_in,
  output reg [`NSLAVE-1:0] flags,
  output wire all_done
);
  genvar i;
  generate
    for (i = 0; i < `NSLAVE; i = i + 1) begin : g_flag
      always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          flags[i] <= 1'b0;
        end else if (done_in[i]) begin
          // Report beats the clear so a fast slave is not lost
          flags[i] <= 1'b1;
        end else if (clear) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate
  assign all_done = &flags;
endmodule // slave_done_flags

// File: test/backlash_sequence_controller_sva.sv
`timescale 1ns/1ps
`include "gear_play_map.vh"
module backlash_sequence_controller_sva (
  input wire clock,
  input wire rst_b,
  input wire load_variation,
  input wire run_order,
  input wire closed_loop,
  input wire torque_limit_reached,
  input wire [`NSLAVE-1:0] slave_done,
  input wire [2:0] drive_cmd,
  input wire torque_limit_on,
  input wire sequence_busy,
  input wire [`NSLAVE-1:0] slave_comp,
  input wire load_error_out,
  input wire [`NSLAVE-1:0] slave_flags_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_stall;
    torque_limit_on && torque_limit_reached;
  endsequence
  // Two samples of the load input, since the reaction lags by two cycles
  sequence s_hold;
    drive_cmd == `CMD_HOLD && load_variation && $past(load_variation)
      && run_order && $past(run_order);
  endsequence
  a_load_flag: assert property (
    load_variation |-> ##2 load_error_out) else $error("load flag late");
  a_stall_ends: assert property (
    s_stall |=> !torque_limit_on) else $error("limit phase kept");
  a_limit_runs: assert property (
    torque_limit_on |-> drive_cmd == `CMD_RUN && sequence_busy)
    else $error("limit phase not running");
  a_master_waits: assert property (
    |slave_comp |-> !torque_limit_on
      && drive_cmd == (closed_loop ? `CMD_ZERO : `CMD_RAMP))
    else $error("master moves during slaves");
  a_flag_sets: assert property (
    slave_comp[0] && slave_done[0] |-> ##[1:2] slave_flags_out[0])
    else $error("done flag not set");
  a_flags_clear: assert property (
    $rose(sequence_busy) |-> ##[0:2] slave_flags_out == 4'h0)
    else $error("done flags not cleared");
  a_hold_kept: assert property (
    s_hold |=> drive_cmd == `CMD_HOLD) else $error("hold speed lost");
  a_fallback_run: assert property (
    drive_cmd == `CMD_FALLBACK |-> $past(run_order, 2))
    else $error("fallback without run");
endmodule // backlash_sequence_controller_sva

// File: test/slave_drives_model.sv
`timescale 1ns/1ps
`include "gear_play_map.vh"
module slave_drives_model #(parameter int LAT = 5) (
  input wire clock,
  input wire rst_b,
  input wire slow,
  input wire [`NSLAVE-1:0] slave_comp,
  output logic [`NSLAVE-1:0] slave_done
);
  int cnt [`NSLAVE];
  // Each slave reports only after its own run, held until the order drops
  always @(posedge clock or negedge rst_b) begin
    for (int i = 0; i < `NSLAVE; i++) begin
      if (!rst_b || !slave_comp[i]) begin
        cnt[i] <= 0;
        slave_done[i] <= 1'b0;
      end else if (cnt[i] >= (slow ? 4 * LAT : LAT)) begin
        slave_done[i] <= 1'b1;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule // slave_drives_model

// File: test/backlash_sequence_controller_tb_top.sv
`timescale 1ns/1ps
`include "gear_play_map.vh"
module backlash_sequence_controller_tb_top;
  logic clock = 0, rst_b = 0, lv = 0, run = 0, halt = 0, dir = 0, cl = 0;
  logic mreq = 0, link = 0, mst = 0, cw = 0, cseq = 0, cfb = 1, stall = 0;
  logic slow = 0, lim, busy, lerr, ract;
  logic [2:0] creact = 1, cmd;
  logic [1:0] cmode = 0;
  logic [15:0] stime = 16'h0008;
  logic [3:0] done, comp, flags, seen, peak;
  logic [7:0] cmds;
  int n_errors = 0, total_checks = 0;
  always #2 clock = ~clock;
  always @(negedge clock) begin
    cmds[cmd] = 1'b1;
    seen = seen | comp;
    if ($countones(comp) > peak) peak = $countones(comp);
  end
  backlash_sequence_controller uut (.clock(clock), .rst_b(rst_b),
    .load_variation(lv), .run_order(run), .halt(halt), .direction(dir),
    .closed_loop(cl), .master_request(mreq), .link_mode(link),
    .master_role(mst), .cfg_write(cw), .cfg_reaction(creact),
    .cfg_gear_play_mode(cmode), .cfg_gear_play_sequencing(cseq),
    .cfg_slave_done_feedback_use(cfb), .slave_time(stime),
    .torque_limit_reached(stall), .slave_done(done), .drive_cmd(cmd),
    .torque_limit_on(lim), .sequence_busy(busy), .slave_comp(comp),
    .load_error_out(lerr), .reaction_active_out(ract),
    .slave_flags_out(flags));
  slave_drives_model #(.LAT(5)) sdm (.clock(clock), .rst_b(rst_b),
    .slow(slow), .slave_comp(comp), .slave_done(done));
  task cmp(input logic [3:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task do_rst(input int n);
    @(posedge clock);
    {rst_b, lv, run, halt, dir, mreq, stall, cw} <= 0;
    repeat (n) @(posedge clock);
    cmp(cmd, `CMD_RAMP);
    cmp({lim, busy, lerr, ract}, 0);
    cmp(comp | flags, 0);
    rst_b <= 1;
  endtask
  task cfg(input [2:0] r, input [1:0] m, input s, f);
    @(posedge clock) {cw, creact, cmode, cseq, cfb} <= {1'b1, r, m, s, f};
    @(posedge clock) cw <= 0;
  endtask
  task wlim;
    for (int i = 0; i < 400 && lim !== 1'b1; i++) @(negedge clock);
  endtask
  task stall_p;
    @(posedge clock) stall <= 1;
    @(posedge clock) stall <= 0;
    cyc(3);
    cmp(lim, 0);
  endtask
  task t_react;
    logic [2:0] e;
    for (int k = 0; k < 8; k++) begin
      do_rst(2);
      if (k > 0) cfg(3'(k - 1), 0, 0, 1);
      e = (k == 0) ? `CMD_FREEWHEEL : 3'(k - 1);
      @(posedge clock) run <= 1;
      cyc(3);
      cmp(lim, 0);
      @(posedge clock) lv <= 1;
      cyc(4);
      cmp(cmd, e);
      cmp(lerr, 1);
      @(posedge clock) run <= 0;
      cyc(3);
      if (e == `CMD_FALLBACK || e == `CMD_HOLD) cmp(cmd == e, 0);
    end
  endtask
  task t_start;
    do_rst(2);
    cfg(1, 1, 0, 1);
    @(posedge clock) run <= 1;
    cyc(3);
    cmp(lim, 1);
    cmp(cmd, `CMD_RUN);
    stall_p;
    @(posedge clock) halt <= 1;
    cyc(3);
    @(posedge clock) halt <= 0;
    cyc(3);
    cmp(lim, 1);
    stall_p;
    @(posedge clock) dir <= ~dir;
    cyc(6);
    cmp(lim, 0);
  endtask
  task t_dir;
    for (int c = 0; c < 2; c++) begin
      do_rst(2);
      @(posedge clock) cl <= c[0];
      cfg(1, 2, 0, 1);
      @(posedge clock) run <= 1;
      cyc(3);
      stall_p;
      cmds = 0;
      @(posedge clock) dir <= ~dir;
      wlim;
      cmp(lim, 1);
      cmp(cmds[c ? `CMD_ZERO : `CMD_RAMP], 1);
    end
  endtask
  task t_master(input logic s, f, sl);
    do_rst(2);
    @(posedge clock) {link, mst, cl, slow} <= {3'b111, sl};
    cfg(1, 3, s, f);
    @(posedge clock) run <= 1;
    cyc(6);
    cmp(busy, 0);
    seen = 0;
    peak = 0;
    @(posedge clock) mreq <= 1;
    wlim;
    cmp(lim, 1);
    cmp(seen, 4'hf);
    cmp(peak, s ? 4 : 1);
    cyc(2);
    if (f) cmp(flags, 4'hf);
    stall_p;
    @(posedge clock) {mreq, run} <= 0;
  endtask
  task close_out;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Whole run is a few hundred cycles; the limit leaves wide margin
  initial begin
    #100000;
    n_errors++;
    close_out;
  end
  initial begin
    do_rst(16);
    t_react;
    t_start;
    t_dir;
    t_master(0, 1, 0);
    t_master(1, 1, 1);
    t_master(0, 0, 1);
    t_master(1, 0, 0);
    close_out;
  end
endmodule // backlash_sequence_controller_tb_top
bind backlash_sequence_controller backlash_sequence_controller_sva sva (
  .clock(clock), .rst_b(rst_b), .load_variation(load_variation),
  .run_order(run_order), .closed_loop(closed_loop),
  .torque_limit_reached(torque_limit_reached), .slave_done(slave_done),
  .drive_cmd(drive_cmd), .torque_limit_on(torque_limit_on),
  .sequence_busy(sequence_busy), .slave_comp(slave_comp),
  .load_error_out(load_error_out), .slave_flags_out(slave_flags_out));
